/* rtl/gfx_plane_pkg.sv */
// Constants for the graphics/attribute register slice.
// Assumes host I/O decode supplies a 16-bit port address per access.
package gfx_plane_pkg;
    // I/O port addresses
    localparam logic [15:0] PORT_GFX_INDEX  = 16'h03CE;
    localparam logic [15:0] PORT_GFX_DATA   = 16'h03CF;
    localparam logic [15:0] PORT_ATTR_WRITE = 16'h03C0;
    localparam logic [15:0] PORT_ATTR_READ  = 16'h03C1;
    localparam logic [15:0] PORT_STATUS1_M  = 16'h03BA;
    localparam logic [15:0] PORT_STATUS1_C  = 16'h03DA;
    // Graphics register offsets
    localparam logic [7:0]  OFS_MISC        = 8'h06;
    localparam logic [7:0]  OFS_DONT_CARE   = 8'h07;
    localparam logic [7:0]  OFS_WRITE_MASK  = 8'h08;
    // Attribute mode register index
    localparam logic [4:0]  ATTR_MODE_IDX   = 5'h10;
    // Field positions
    localparam int MISC_GSEL_BIT  = 0;
    localparam int MISC_CHAIN_BIT = 1;
    localparam int MISC_MAP_LO    = 2;
    localparam int ATTR_PAS_BIT   = 5;
    // Reset values (documented as undefined; zero chosen)
    localparam logic [7:0]  RST_REG         = 8'h00;
    // Memory window bases and ends (address bits 19:0)
    localparam logic [19:0] WIN_A0000       = 20'hA_0000;
    localparam logic [19:0] WIN_B0000       = 20'hB_0000;
    localparam logic [19:0] WIN_B7FFF       = 20'hB_7FFF;
    localparam logic [19:0] WIN_B8000       = 20'hB_8000;
    localparam logic [19:0] WIN_BFFFF       = 20'hB_FFFF;
    // Memory-map field encodings
    localparam logic [1:0]  MAP_128K_A      = 2'b00;
    localparam logic [1:0]  MAP_128K_B      = 2'b01;
    localparam logic [1:0]  MAP_32K_MONO    = 2'b10;
    localparam logic [1:0]  MAP_32K_COLOR   = 2'b11;
    typedef enum logic [0:0] {
        FF_INDEX = 1'b0,
        FF_DATA  = 1'b1
    } attr_ff_t;
endpackage

/* rtl/plane_write_merge.sv */
// Per-plane write merge: bit mask picks new data or the read latch.
// Assumes 4 planes of 8 bits packed plane 3 down to plane 0.
`timescale 1ns/100ps
module plane_write_merge #(
    parameter int PLANES = 4,
    parameter int WIDTH  = 8
) (
    // Inputs
    input  wire logic [PLANES*WIDTH-1:0] new_data,
    input  wire logic [PLANES*WIDTH-1:0] latch_data,
    input  wire logic [WIDTH-1:0]        plane_bit_mask,
    // Result
    output logic      [PLANES*WIDTH-1:0] merged
);
    always_comb begin
        for (int p = 0; p < PLANES; p++) begin
            merged[p*WIDTH +: WIDTH] =
                (new_data[p*WIDTH +: WIDTH] & plane_bit_mask) |
                (latch_data[p*WIDTH +: WIDTH] & ~plane_bit_mask);
        end
    end
endmodule

/* rtl/vga_graphics_plane_control.sv */
// Graphics misc/don't-care/bit-mask registers and attribute index port.
// Assumes one host I/O access per io_wr/io_rd pulse, synchronous to clk.
//
// Behaviour
// - Graphics registers reached via index port then data port; misc at 6
// - Upper four bits of misc and don't-care read as zero
// - Memory-map field selects host window 128K, B0000 32K or B8000 32K
// - Chain bit stored and read back, no other effect
// - Graphics-select one means graphics, zero means alphanumeric
// - Graphics-select mirrors bit 0 of attribute mode register
// - Don't-care bit one drops that plane from compare
// - Mask bit zero leaves that bit unchanged in every plane
// - Masked-off bits written from the read latch
// - Mask applies to all host writes and all planes together
// - One write port loads attribute index then selected data
// - Flip-flop toggles each attribute write, selects index or data
// - Status register one read forces flip-flop to index state
// - Compare read mode returns per-bit compare result across planes not dropped by don't-care
// - Attribute index field selects data register for access
// - Palette source zero blanks display, allows palette writes
`timescale 1ns/100ps
module vga_graphics_plane_control
    import gfx_plane_pkg::*;
#(
    parameter int PLANES = 4,
    parameter int WIDTH  = 8
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    clk_en,
    // Host I/O port access
    input  wire logic [15:0]             io_addr,
    input  wire logic                    io_wr,
    input  wire logic                    io_rd,
    input  wire logic [7:0]              io_wdata,
    output logic      [7:0]              io_rdata,
    output logic                         io_rdata_valid,
    // Attribute data register side
    output logic      [4:0]              attr_data_sel,
    output logic                         attr_data_wr,
    output logic      [7:0]              attr_data_wdata,
    input  wire logic [7:0]              attr_data_rdata,
    // Host memory side
    input  wire logic [19:0]             mem_addr,
    output logic                         mem_claim,
    input  wire logic                    mem_rd,
    input  wire logic                    mem_wr,
    input  wire logic [PLANES*WIDTH-1:0] mem_new_data,
    input  wire logic [PLANES*WIDTH-1:0] plane_rdata,
    input  wire logic [3:0]              color_compare,
    input  wire logic                    read_mode_select,
    output logic      [PLANES*WIDTH-1:0] plane_wdata,
    output logic                         plane_we,
    output logic      [WIDTH-1:0]        compare_result,
    // Display control
    output logic                         graphics_select,
    output logic                         display_blank,
    output logic                         palette_wr_enable
);
    logic [7:0]              gfx_index_ff;
    logic [7:0]              graphics_misc_reg_ff;
    logic [3:0]              color_dont_care_reg_ff;
    logic [7:0]              plane_write_mask_reg_ff;
    logic [7:0]              attribute_index_reg_ff;
    logic                    attr_gsel_ff;
    attr_ff_t                attr_ff;
    logic [PLANES*WIDTH-1:0] read_latch_ff;
    logic [PLANES*WIDTH-1:0] merged;

    function automatic logic in_range(input logic [19:0] a,
                                      input logic [19:0] lo,
                                      input logic [19:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    wire logic acc_gidx = clk_en && (io_addr == PORT_GFX_INDEX);
    wire logic acc_gdat = clk_en && (io_addr == PORT_GFX_DATA);
    wire logic acc_attr = clk_en && (io_addr == PORT_ATTR_WRITE);
    wire logic acc_stat = clk_en && ((io_addr == PORT_STATUS1_M) ||
                                     (io_addr == PORT_STATUS1_C));
    wire logic attr_data_phase = acc_attr && io_wr && (attr_ff == FF_DATA);
    wire logic mode_write = attr_data_phase &&
        (attribute_index_reg_ff[4:0] == ATTR_MODE_IDX);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gfx_index_ff <= RST_REG;
        end else if (acc_gidx && io_wr) begin
            gfx_index_ff <= io_wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            graphics_misc_reg_ff    <= RST_REG;
            color_dont_care_reg_ff  <= RST_REG[3:0];
            plane_write_mask_reg_ff <= RST_REG;
        end else begin
            if (acc_gdat && io_wr) begin
                case (gfx_index_ff)
                    OFS_MISC:       graphics_misc_reg_ff    <= io_wdata;
                    OFS_DONT_CARE:  color_dont_care_reg_ff  <= io_wdata[3:0];
                    OFS_WRITE_MASK: plane_write_mask_reg_ff <= io_wdata;
                    default: ;
                endcase
            end else if (mode_write) begin
                graphics_misc_reg_ff[MISC_GSEL_BIT] <= io_wdata[0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            attr_ff <= FF_INDEX;
        end else if (acc_stat && io_rd) begin
            attr_ff <= FF_INDEX;
        end else if (acc_attr && io_wr) begin
            attr_ff <= (attr_ff == FF_INDEX) ? FF_DATA : FF_INDEX;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            attribute_index_reg_ff <= RST_REG;
        end else if (acc_attr && io_wr && attr_ff == FF_INDEX) begin
            attribute_index_reg_ff <= {2'b00, io_wdata[5:0]};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            attr_data_wr    <= 1'b0;
            attr_data_sel   <= 5'h00;
            attr_data_wdata <= RST_REG;
            attr_gsel_ff    <= 1'b0;
        end else if (clk_en) begin
            attr_data_wr    <= attr_data_phase;
            attr_data_sel   <= attribute_index_reg_ff[4:0];
            attr_data_wdata <= io_wdata;
            if (acc_gdat && io_wr && gfx_index_ff == OFS_MISC) begin
                attr_gsel_ff <= io_wdata[0];
            end else if (mode_write) begin
                attr_gsel_ff <= io_wdata[0];
            end
        end
    end

    // Register read-back
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            io_rdata       <= RST_REG;
            io_rdata_valid <= 1'b0;
        end else if (clk_en) begin
            io_rdata_valid <= io_rd;
            if (io_rd) begin
                io_rdata <= RST_REG;
                if (io_addr == PORT_GFX_INDEX) begin
                    io_rdata <= gfx_index_ff;
                end else if (io_addr == PORT_GFX_DATA) begin
                    case (gfx_index_ff)
                        OFS_MISC: io_rdata <= {4'h0,
                                               graphics_misc_reg_ff[3:0]};
                        OFS_DONT_CARE: io_rdata <= {4'h0,
                                                    color_dont_care_reg_ff};
                        OFS_WRITE_MASK: io_rdata <= plane_write_mask_reg_ff;
                        default: io_rdata <= RST_REG;
                    endcase
                end else if (io_addr == PORT_ATTR_WRITE) begin
                    io_rdata <= attribute_index_reg_ff;
                end else if (io_addr == PORT_ATTR_READ) begin
                    io_rdata <= attr_data_rdata;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_claim <= 1'b0;
        end else if (clk_en) begin
            case (graphics_misc_reg_ff[MISC_MAP_LO +: 2])
                MAP_128K_A, MAP_128K_B:
                    mem_claim <= in_range(mem_addr, WIN_A0000, WIN_BFFFF);
                MAP_32K_MONO:
                    mem_claim <= in_range(mem_addr, WIN_B0000, WIN_B7FFF);
                MAP_32K_COLOR:
                    mem_claim <= in_range(mem_addr, WIN_B8000, WIN_BFFFF);
                default: mem_claim <= 1'b0;
            endcase
        end
    end

    // Read latch and colour compare
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            read_latch_ff  <= '0;
            compare_result <= '0;
        end else if (clk_en && mem_rd) begin
            read_latch_ff <= plane_rdata;
            if (read_mode_select) begin
                for (int b = 0; b < WIDTH; b++) begin
                    compare_result[b] <= 1'b1;
                    for (int p = 0; p < PLANES; p++) begin
                        if (!color_dont_care_reg_ff[p] &&
                            plane_rdata[p*WIDTH+b] != color_compare[p]) begin
                            compare_result[b] <= 1'b0;
                        end
                    end
                end
            end
        end
    end

    plane_write_merge #(
        .PLANES (PLANES),
        .WIDTH  (WIDTH)
    ) u_merge (
        .new_data       (mem_new_data),
        .latch_data     (read_latch_ff),
        .plane_bit_mask (plane_write_mask_reg_ff),
        .merged         (merged)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            plane_wdata <= '0;
            plane_we    <= 1'b0;
        end else if (clk_en) begin
            plane_we <= mem_wr;
            if (mem_wr) begin
                plane_wdata <= merged;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            graphics_select   <= 1'b0;
            display_blank     <= 1'b1;
            palette_wr_enable <= 1'b1;
        end else if (clk_en) begin
            graphics_select   <= graphics_misc_reg_ff[MISC_GSEL_BIT];
            display_blank     <= !attribute_index_reg_ff[ATTR_PAS_BIT];
            palette_wr_enable <= !attribute_index_reg_ff[ATTR_PAS_BIT];
        end
    end

    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_status_read_idx: assert property (
        acc_stat && io_rd |=> attr_ff == FF_INDEX)
        else $error("attribute phase not reset by status read");
    a_attr_toggle: assert property (
        acc_attr && io_wr && !(acc_stat && io_rd) |=>
        attr_ff != $past(attr_ff))
        else $error("attribute phase did not toggle");
    a_misc_upper_zero: assert property (
        clk_en && io_rd && io_addr == PORT_GFX_DATA &&
        gfx_index_ff == OFS_MISC |=> io_rdata[7:4] == 4'h0)
        else $error("misc upper bits not zero");
    a_mask_keeps: assert property (
        clk_en && mem_wr |=> ((plane_wdata ^ $past(read_latch_ff)) &
        ~{PLANES{$past(plane_write_mask_reg_ff)}}) == '0)
        else $error("masked bit not from latch");
    a_gsel_mirror: assert property (
        ##1 clk_en |-> attr_gsel_ff == graphics_misc_reg_ff[0])
        else $error("graphics select copies differ");
    a_index_load: assert property (
        acc_attr && io_wr && attr_ff == FF_INDEX && !(acc_stat && io_rd)
        |=> attribute_index_reg_ff[5:0] == $past(io_wdata[5:0]))
        else $error("attribute index not loaded");
    a_data_route: assert property (
        attr_data_phase |=> attr_data_wr &&
        attr_data_sel == $past(attribute_index_reg_ff[4:0]))
        else $error("attribute data write misrouted");
    a_blank_pas: assert property (
        clk_en |=> display_blank == !$past(attribute_index_reg_ff[5]))
        else $error("blank does not follow palette source");
endmodule

/* test/tb_top.sv */
// Self-checking bench for the graphics plane control register slice.
// Assumes every taken request is answered one clock after its edge.
`timescale 1ns/100ps
module tb_top;
    import gfx_plane_pkg::*;
    logic        clk;
    logic        rstn;
    logic        clk_en;
    logic [15:0] io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        io_rdata_valid;
    logic [4:0]  attr_data_sel;
    logic        attr_data_wr;
    logic [7:0]  attr_data_wdata;
    logic [7:0]  attr_data_rdata;
    logic [19:0] mem_addr;
    logic        mem_claim;
    logic        mem_rd;
    logic        mem_wr;
    logic [31:0] mem_new_data;
    logic [31:0] plane_rdata;
    logic [3:0]  color_compare;
    logic        read_mode_select;
    logic [31:0] plane_wdata;
    logic        plane_we;
    logic [7:0]  compare_result;
    logic        graphics_select;
    logic        display_blank;
    logic        palette_wr_enable;
    int          errors;
    int          checks_done;
    logic [19:0] addrs[8];

    vga_graphics_plane_control i_vga_graphics_plane_control (
        .clk(clk), .rstn(rstn), .clk_en(clk_en),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rdata_valid(io_rdata_valid),
        .attr_data_sel(attr_data_sel), .attr_data_wr(attr_data_wr),
        .attr_data_wdata(attr_data_wdata),
        .attr_data_rdata(attr_data_rdata),
        .mem_addr(mem_addr), .mem_claim(mem_claim),
        .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_new_data(mem_new_data), .plane_rdata(plane_rdata),
        .color_compare(color_compare),
        .read_mode_select(read_mode_select),
        .plane_wdata(plane_wdata), .plane_we(plane_we),
        .compare_result(compare_result),
        .graphics_select(graphics_select),
        .display_blank(display_blank),
        .palette_wr_enable(palette_wr_enable)
    );

    always #10 clk = ~clk;

    task automatic complete_run();
        if (errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    // Leading edge wait keeps a strobe from being set twice in one step
    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
    endtask

    task automatic io_read(input logic [15:0] a, output logic [7:0] d);
        int n;
        @(negedge clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        n = 0;
        while (io_rdata_valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (io_rdata_valid !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: no read answer", $time);
            complete_run();
        end
        d = io_rdata;
    endtask

    task automatic gr_write(input logic [7:0] ofs, input logic [7:0] d);
        io_write(PORT_GFX_INDEX, ofs);
        io_write(PORT_GFX_DATA, d);
    endtask

    task automatic gr_read(input logic [7:0] ofs, output logic [7:0] d);
        io_write(PORT_GFX_INDEX, ofs);
        io_read(PORT_GFX_DATA, d);
    endtask

    // Window decode of the memory-map field
    function automatic logic in_win(input int map, input int a);
        case (map)
            2: return a >= 20'hB_0000 && a <= 20'hB_7FFF;
            3: return a >= 20'hB_8000 && a <= 20'hB_FFFF;
            default: return a >= 20'hA_0000 && a <= 20'hB_FFFF;
        endcase
    endfunction

    initial begin
        logic [7:0]  v;
        logic [7:0]  rd;
        logic [31:0] lat;
        logic [31:0] nw;
        logic [31:0] exp;
        int          ok;
        clk = 0; rstn = 0; clk_en = 1; io_addr = 0; io_wr = 0; io_rd = 0;
        io_wdata = 0; attr_data_rdata = 0; mem_addr = 0; mem_rd = 0;
        mem_wr = 0; mem_new_data = 0; plane_rdata = 0; color_compare = 0;
        read_mode_select = 0; errors = 0; checks_done = 0;
        addrs = '{20'h9_FFFF, 20'hA_0000, 20'hA_FFFF, 20'hB_0000,
                  20'hB_7FFF, 20'hB_8000, 20'hB_FFFF, 20'hC_0000};
        repeat (12) @(negedge clk);
        rstn = 1;
        void'($urandom(32'h34ff_f4d0));
        // Every register is written before it is relied on
        for (int i = 0; i < 3; i++) begin
            repeat (4) begin
                v = 8'($urandom);
                gr_write(8'(6 + i), v);
                gr_read(8'(6 + i), rd);
                check(rd, (i < 2) ? (v & 8'h0F) : v);
                if (i == 0) check(graphics_select, v[0]);
            end
        end
        gr_write(8'h09, 8'hA5);
        gr_read(8'h09, rd);
        check(rd, 8'h00);
        for (int m = 0; m < 4; m++) begin
            gr_write(OFS_MISC, 8'(m << 2));
            for (int k = 0; k < 8; k++) begin
                @(negedge clk);
                mem_addr = addrs[k];
                @(negedge clk);
                check(mem_claim, in_win(m, addrs[k]));
            end
        end
        repeat (4) begin
            v = 8'($urandom);
            lat = $urandom;
            nw = $urandom;
            gr_write(OFS_WRITE_MASK, v);
            plane_rdata = lat;
            mem_rd = 1'b1;
            @(negedge clk);
            mem_rd = 1'b0;
            mem_new_data = nw;
            mem_wr = 1'b1;
            @(negedge clk);
            mem_wr = 1'b0;
            for (int p = 0; p < 4; p++)
                exp[p*8 +: 8] = (nw[p*8 +: 8] & v) | (lat[p*8 +: 8] & ~v);
            check(plane_we, 1'b1);
            check(plane_wdata, exp);
        end
        read_mode_select = 1'b1;
        repeat (6) begin
            v = 8'($urandom);
            gr_write(OFS_DONT_CARE, v);
            color_compare = 4'($urandom);
            plane_rdata = $urandom;
            mem_rd = 1'b1;
            @(negedge clk);
            mem_rd = 1'b0;
            for (int b = 0; b < 8; b++) begin
                ok = 1;
                for (int p = 0; p < 4; p++)
                    if (!v[p] && plane_rdata[p*8 + b] != color_compare[p])
                        ok = 0;
                exp[b] = ok[0];
            end
            check(compare_result, exp[7:0]);
        end
        // Status read puts the attribute port at its index step
        io_read(PORT_STATUS1_C, rd);
        io_write(PORT_ATTR_WRITE, 8'h10);
        check(display_blank & palette_wr_enable, 1'b1);
        io_write(PORT_ATTR_WRITE, 8'h01);
        check({attr_data_wr, attr_data_sel, attr_data_wdata},
              {1'b1, 5'h10, 8'h01});
        io_read(PORT_ATTR_WRITE, rd);
        check(rd, 8'h10);
        check(graphics_select, 1'b1);
        io_write(PORT_ATTR_WRITE, 8'h05);
        io_read(PORT_STATUS1_M, rd);
        io_write(PORT_ATTR_WRITE, 8'h23);
        check(attr_data_wr, 1'b0);
        io_write(PORT_ATTR_WRITE, 8'h2A);
        check({attr_data_wr, attr_data_sel, attr_data_wdata},
              {1'b1, 5'h03, 8'h2A});
        check(display_blank | palette_wr_enable, 1'b0);
        attr_data_rdata = 8'($urandom);
        io_read(PORT_ATTR_READ, rd);
        check(rd, attr_data_rdata);
        io_read(PORT_STATUS1_C, rd);
        io_write(PORT_ATTR_WRITE, 8'h10);
        @(negedge clk);
        check(display_blank & palette_wr_enable, 1'b1);
        gr_write(OFS_MISC, 8'h00);
        @(negedge clk);
        check(graphics_select, 1'b0);
        // Writes while the clock enable is low must not land
        gr_write(OFS_WRITE_MASK, 8'h3C);
        clk_en = 1'b0;
        io_write(PORT_GFX_DATA, 8'hC3);
        clk_en = 1'b1;
        gr_read(OFS_WRITE_MASK, rd);
        check(rd, 8'h3C);
        complete_run();
    end
endmodule
